// file: rtl/raster_op_unit.sv
// Shift, mask and logic datapath: control and function registers, word swap,
// barrel shifter, 16-word queue and raster logic unit.
// Assumes all link inputs are synchronous to clk_i.
//
// Function
// RULE1: Control register: left, right, shift, order fields
// RULE2: Control loads on control strobe rising edge
// RULE3: Control register is write only, no readback
// RULE4: Control held unchanged while line mode high
// RULE5: Masked-off bits keep destination; enables gate masks
// RULE6: Left field n clears n top bits
// RULE7: Right field n sets n+1 top bits
// RULE8: Controller derives mask fields from destination address
// RULE9: Sixteen shift amounts from shift field
// RULE10: Output is upper word of shifted pair
// RULE11: Order high puts newest word most significant
// RULE12: Controller sets order bit by fetch direction
// RULE13: Shifter is 32-to-16 mux of held/incoming
// RULE14: Swap exchanges words, never bits within
// RULE15: Four-bit function register selects sixteen operations
// RULE16: Result bit is OR of four minterms
// RULE17: Function loads on function strobe rising edge
// RULE18: Sixteen-word by sixteen-bit queue, separate strobes
// RULE19: One-hot ring pointers cleared by reset
// RULE20: Block mode combines queue word with destination
// RULE21: Line mode combines pixel with addressed bit
// RULE22: Pixel replicated, only addressed bit changes
// RULE23: Both enables: bit needs both masks
// RULE24: Pointers wrap, no full or empty flags
//
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ps
module raster_op_unit
	import bitblt_pkg::*;
#(
	parameter int DEPTH = QUEUE_DEPTH
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset, active high
	bitblt_link_if.device link // Pins toward the controller
);

	////////////////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic [WORD_W-1:0] left_mask(input logic [FIELD_W-1:0] n);
		left_mask = 16'hFFFF >> n; // [RULE6]
	endfunction : left_mask

	function automatic logic [WORD_W-1:0] right_mask(input logic [FIELD_W-1:0] n);
		logic [4:0] amt;
		amt = {1'b0, n} + 5'h01;
		right_mask = ~(16'hFFFF >> amt); // [RULE7]
	endfunction : right_mask

	function automatic logic [WORD_W-1:0] barrel(input logic [WORD_W-1:0] msw,
		input logic [WORD_W-1:0] lsw, input logic [FIELD_W-1:0] i);
		logic [2*WORD_W-1:0] pair;
		pair = {msw, lsw} << i; // [RULE9] [RULE10]
		barrel = pair[2*WORD_W-1:WORD_W]; // [RULE13]
	endfunction : barrel

	function automatic logic [WORD_W-1:0] rop(input logic [FUNC_W-1:0] f,
		input logic [WORD_W-1:0] s, input logic [WORD_W-1:0] d);
		rop = ({WORD_W{f[3]}} & ~s & ~d) | ({WORD_W{f[2]}} & ~s & d) |
			({WORD_W{f[1]}} & s & ~d) | ({WORD_W{f[0]}} & s & d); // [RULE16]
	endfunction : rop

	////////////////////////////////////////////////////////////////////////////////////////
	// Control and function registers

	// Write-only: no path leads from these registers back to the data port [RULE3]
	logic [CTRL_W-1:0] control_q; // [RULE1]
	logic [CTRL_W-1:0] control_shadow_q;
	logic [FUNC_W-1:0] function_q; // [RULE15]
	logic [FUNC_W-1:0] function_shadow_q;
	logic control_strobe_prev_q;
	logic function_strobe_prev_q;
	logic control_rise;
	logic function_rise;

	assign control_rise = !control_strobe_prev_q && link.control_load_strobe_n;
	assign function_rise = !function_strobe_prev_q && link.function_load_strobe_n;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control_strobe_prev_q <= 1'b1;
			function_strobe_prev_q <= 1'b1;
		end else begin
			control_strobe_prev_q <= link.control_load_strobe_n;
			function_strobe_prev_q <= link.function_load_strobe_n;
		end
	end

	// Data is followed while the strobe is low and committed when it rises
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control_shadow_q <= CTRL_RESET;
		end else if (!link.control_load_strobe_n) begin
			control_shadow_q <= link.data[CTRL_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control_q <= CTRL_RESET;
		end else if (control_rise && !link.line_mode) begin // [RULE2] [RULE4]
			control_q <= control_shadow_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			function_shadow_q <= FUNC_RESET;
		end else if (!link.function_load_strobe_n) begin
			function_shadow_q <= link.data[FUNC_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			function_q <= FUNC_RESET;
		end else if (function_rise) begin // [RULE17]
			function_q <= function_shadow_q;
		end
	end

	logic [FIELD_W-1:0] right_edge_field;
	logic [FIELD_W-1:0] left_edge_field;
	logic [FIELD_W-1:0] shift_count_field;
	logic word_order_select;

	assign right_edge_field = control_q[RIGHT_FIELD_LSB +: FIELD_W];
	assign left_edge_field = control_q[LEFT_FIELD_LSB +: FIELD_W];
	assign shift_count_field = control_q[SHIFT_FIELD_LSB +: FIELD_W];
	assign word_order_select = control_q[ORDER_BIT];

	////////////////////////////////////////////////////////////////////////////////////////
	// Input latches

	logic [WORD_W-1:0] incoming_word_latch_q;
	logic [WORD_W-1:0] held_source_word_q;
	logic [WORD_W-1:0] dest_latch_q;
	logic pixel_in_latch_q;

	// A new source word pushes the previous one into the held latch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			incoming_word_latch_q <= WORD_RESET;
			held_source_word_q <= WORD_RESET;
		end else if (link.source_load) begin
			incoming_word_latch_q <= link.data;
			held_source_word_q <= incoming_word_latch_q; // [RULE13]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dest_latch_q <= WORD_RESET;
		end else if (link.dest_load) begin
			dest_latch_q <= link.data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pixel_in_latch_q <= 1'b0;
		end else if (link.pixel_load) begin
			pixel_in_latch_q <= link.data[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Word swap and barrel shifter

	logic [WORD_W-1:0] shifter_msw;
	logic [WORD_W-1:0] shifter_lsw;
	logic [WORD_W-1:0] shifted_word;

	// Whole words trade places; bit order inside each word is untouched [RULE14]
	assign shifter_msw = word_order_select ? incoming_word_latch_q : held_source_word_q; // [RULE11]
	assign shifter_lsw = word_order_select ? held_source_word_q : incoming_word_latch_q; // [RULE11]
	assign shifted_word = barrel(shifter_msw, shifter_lsw, shift_count_field);

	////////////////////////////////////////////////////////////////////////////////////////
	// Queue with one-hot ring pointers

	logic [WORD_W-1:0] queue_mem [DEPTH]; // [RULE18]
	logic [DEPTH-1:0] write_ptr_q;
	logic [DEPTH-1:0] read_ptr_q;
	logic [WORD_W-1:0] queue_head;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			write_ptr_q <= {{(DEPTH-1){1'b0}}, 1'b1}; // [RULE19]
		end else if (link.queue_write_strobe) begin
			write_ptr_q <= {write_ptr_q[DEPTH-2:0], write_ptr_q[DEPTH-1]}; // [RULE24]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			read_ptr_q <= {{(DEPTH-1){1'b0}}, 1'b1}; // [RULE19]
		end else if (link.queue_read_strobe) begin
			read_ptr_q <= {read_ptr_q[DEPTH-2:0], read_ptr_q[DEPTH-1]}; // [RULE24]
		end
	end

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_entry
			always_ff @(posedge clk_i) begin
				if (link.queue_write_strobe && write_ptr_q[g]) begin
					queue_mem[g] <= shifted_word;
				end
			end
		end
	endgenerate

	always_comb begin
		queue_head = WORD_RESET;
		for (int k = 0; k < DEPTH; k++) begin
			if (read_ptr_q[k]) begin
				queue_head = queue_mem[k];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Raster logic unit

	logic [WORD_W-1:0] edge_mask;
	logic [WORD_W-1:0] pixel_mask;
	logic [WORD_W-1:0] source_word;
	logic [WORD_W-1:0] write_mask;
	logic [WORD_W-1:0] logic_out;
	logic [WORD_W-1:0] result_q;

	always_comb begin
		edge_mask = 16'hFFFF;
		if (link.left_edge_enable) begin
			edge_mask = edge_mask & left_mask(left_edge_field); // [RULE5] [RULE23]
		end
		if (link.right_edge_enable) begin
			edge_mask = edge_mask & right_mask(right_edge_field); // [RULE5] [RULE23]
		end
	end

	// Pixel address 0 selects the most significant bit
	assign pixel_mask = 16'h8000 >> link.pixel_bit_select; // [RULE21]
	assign source_word = link.line_mode ? {WORD_W{pixel_in_latch_q}} : queue_head; // [RULE22]
	assign write_mask = link.line_mode ? pixel_mask : edge_mask; // [RULE20] [RULE22]
	assign logic_out = (rop(function_q, source_word, dest_latch_q) & write_mask) |
		(dest_latch_q & ~write_mask); // [RULE5]

	// Block mode updates on a queue read; line mode updates every cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result_q <= WORD_RESET;
		end else if (link.line_mode || link.queue_read_strobe) begin // [RULE20] [RULE21]
			result_q <= logic_out;
		end
	end

	assign link.result = result_q;

endmodule : raster_op_unit

// file: rtl/bitblt_pkg.sv
// Shared constants and types for the raster-operation datapath and its controller.
// Assumes a single 100 MHz clock and a synchronous active-high reset on both ends.
package bitblt_pkg;
	localparam int WORD_W = 16;
	localparam int CTRL_W = 13;
	localparam int FUNC_W = 4;
	localparam int FIELD_W = 4;
	localparam int QUEUE_DEPTH = 16;
	// Control word layout
	localparam int RIGHT_FIELD_LSB = 0;
	localparam int LEFT_FIELD_LSB = 4;
	localparam int SHIFT_FIELD_LSB = 8;
	localparam int ORDER_BIT = 12;
	// Controller command data layout for the address-derived control load
	localparam int START_BIT_LSB = 0;
	localparam int END_BIT_LSB = 4;
	localparam int DIR_BIT = 8;
	localparam int CMD_SHIFT_LSB = 9;
	// Mode command data layout
	localparam int MODE_LINE_BIT = 0;
	localparam int MODE_LEFT_BIT = 1;
	localparam int MODE_RIGHT_BIT = 2;
	localparam int MODE_PIX_LSB = 4;
	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RESET = 13'h0000;
	localparam logic [FUNC_W-1:0] FUNC_RESET = 4'h0;
	localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
	// Strobe low time: 20 ns, at least one cycle
	localparam int CLK_PERIOD_NS = 10;
	localparam int STROBE_LOW_NS = 20;
	localparam int STROBE_LOW_CYCLES =
		(STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] STROBE_LOW_CNT = 4'(STROBE_LOW_CYCLES);
	typedef enum logic [3:0] {
		OP_CTRL_RAW,
		OP_CTRL_ADDR,
		OP_FUNC,
		OP_SOURCE,
		OP_DEST,
		OP_PIXEL,
		OP_QWRITE,
		OP_QREAD,
		OP_MODE
	} op_t;
endpackage : bitblt_pkg

// file: rtl/bitblt_link_if.sv
// Pin-level link between the datapath and its controlling party.
// Assumes both ends share clk_i; strobes ending in _n are active low.
`timescale 1ns/1ps
interface bitblt_link_if;
	logic [15:0] data;
	logic control_load_strobe_n;
	logic function_load_strobe_n;
	logic source_load;
	logic dest_load;
	logic pixel_load;
	logic queue_write_strobe;
	logic queue_read_strobe;
	logic line_mode;
	logic left_edge_enable;
	logic right_edge_enable;
	logic [3:0] pixel_bit_select;
	logic [15:0] result;
	modport device (
		input data, control_load_strobe_n, function_load_strobe_n, source_load, dest_load,
		input pixel_load, queue_write_strobe, queue_read_strobe, line_mode,
		input left_edge_enable, right_edge_enable, pixel_bit_select,
		output result
	);
	modport host (
		output data, control_load_strobe_n, function_load_strobe_n, source_load, dest_load,
		output pixel_load, queue_write_strobe, queue_read_strobe, line_mode,
		output left_edge_enable, right_edge_enable, pixel_bit_select,
		input result
	);
endinterface : bitblt_link_if

// file: rtl/raster_op_controller.sv
// Controlling party: turns bus commands into strobe and latch sequences on the link.
// Assumes a classic Wishbone master on clk_i; one command is run at a time.
`timescale 1ns/1ps
module raster_op_controller
	import bitblt_pkg::*;
(
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Bus strobe
	input wire logic wb_we_i, // Write when high
	input wire logic [3:0] wb_adr_i, // Word address, command code on writes
	input wire logic [1:0] wb_sel_i, // Byte lanes
	input wire logic [15:0] wb_dat_i, // Command data
	output logic [15:0] wb_dat_o, // Last result word read from the queue
	output logic wb_ack_o, // Acknowledge, given only while idle
	bitblt_link_if.host link // Pins toward the datapath
);

	typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_RISE, ST_WAIT1, ST_WAIT2} state_t;

	state_t state_q;
	logic [3:0] count_q;
	logic take;
	op_t cmd_op;
	logic [15:0] ctrl_word;

	// Masks come from start and end bit of the destination; order from fetch direction
	assign ctrl_word = {3'h0, wb_dat_i[DIR_BIT], wb_dat_i[CMD_SHIFT_LSB +: FIELD_W],
		wb_dat_i[START_BIT_LSB +: FIELD_W], wb_dat_i[END_BIT_LSB +: FIELD_W]}; // [RULE8] [RULE12]
	// Busy sequences stretch the bus cycle; reads have no side effect
	assign wb_ack_o = wb_cyc_i && wb_stb_i && (state_q == ST_IDLE);
	// A full-word write to the command code's address issues that command
	assign take = wb_ack_o && wb_we_i && (&wb_sel_i);
	assign cmd_op = op_t'(wb_adr_i);

	////////////////////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			count_q <= 4'h0;
			link.data <= 16'h0000;
			link.control_load_strobe_n <= 1'b1;
			link.function_load_strobe_n <= 1'b1;
			link.source_load <= 1'b0;
			link.dest_load <= 1'b0;
			link.pixel_load <= 1'b0;
			link.queue_write_strobe <= 1'b0;
			link.queue_read_strobe <= 1'b0;
			link.line_mode <= 1'b0;
			link.left_edge_enable <= 1'b0;
			link.right_edge_enable <= 1'b0;
			link.pixel_bit_select <= 4'h0;
		end else begin
			link.source_load <= 1'b0;
			link.dest_load <= 1'b0;
			link.pixel_load <= 1'b0;
			link.queue_write_strobe <= 1'b0;
			link.queue_read_strobe <= 1'b0;
			unique case (state_q)
				ST_IDLE: begin
					if (take) begin
						link.data <= (cmd_op == OP_CTRL_ADDR) ? ctrl_word : wb_dat_i;
						unique case (cmd_op)
							OP_CTRL_RAW, OP_CTRL_ADDR, OP_FUNC: begin
								link.control_load_strobe_n <= (cmd_op == OP_FUNC); // [RULE2]
								link.function_load_strobe_n <= (cmd_op != OP_FUNC); // [RULE17]
								count_q <= STROBE_LOW_CNT;
								state_q <= ST_LOW;
							end
							OP_SOURCE: link.source_load <= 1'b1;
							OP_DEST: link.dest_load <= 1'b1;
							OP_PIXEL: link.pixel_load <= 1'b1;
							OP_QWRITE: link.queue_write_strobe <= 1'b1;
							OP_QREAD: begin
								link.queue_read_strobe <= 1'b1;
								state_q <= ST_WAIT1;
							end
							OP_MODE: begin
								link.line_mode <= wb_dat_i[MODE_LINE_BIT];
								link.left_edge_enable <= wb_dat_i[MODE_LEFT_BIT];
								link.right_edge_enable <= wb_dat_i[MODE_RIGHT_BIT];
								link.pixel_bit_select <= wb_dat_i[MODE_PIX_LSB +: 4];
							end
							default: ;
						endcase
					end
				end
				ST_LOW: begin
					count_q <= count_q - 4'h1;
					if (count_q == 4'h1) begin
						link.control_load_strobe_n <= 1'b1;
						link.function_load_strobe_n <= 1'b1;
						state_q <= ST_RISE;
					end
				end
				ST_RISE: state_q <= ST_IDLE;
				ST_WAIT1: state_q <= ST_WAIT2;
				ST_WAIT2: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 16'h0000;
		end else if (state_q == ST_WAIT2) begin
			wb_dat_o <= link.result;
		end
	end

endmodule : raster_op_controller

// file: tb/bitblt_link_chk.sv
// Checker for the link between the controller and the datapath.
// Assumes it is instantiated beside the link interface and fed with its signals.
`timescale 1ns/1ps
module bitblt_link_chk (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic [15:0] data, // Word to device
	input wire logic control_load_strobe_n, // Control strobe
	input wire logic function_load_strobe_n, // Function strobe
	input wire logic dest_load, // Destination load
	input wire logic pixel_load, // Pixel load
	input wire logic queue_write_strobe, // Queue write
	input wire logic queue_read_strobe, // Queue read
	input wire logic line_mode, // Line drawing
	input wire logic [3:0] pixel_bit_select, // Pixel address
	input wire logic [15:0] result // Device result
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [15:0] dest_q;
	logic pix_q;
	logic [3:0] func_q;
	logic [3:0] fsh_q;
	logic fn_prev_q;
	////////////////////////////////////////////////////////////
	// Shadow copies of the device latches
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dest_q <= 16'h0000;
			pix_q <= 1'b0;
		end else begin
			if (dest_load) dest_q <= data;
			if (pixel_load) pix_q <= data[0];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			func_q <= 4'h0;
			fsh_q <= 4'h0;
			fn_prev_q <= 1'b1;
		end else begin
			fn_prev_q <= function_load_strobe_n;
			if (!function_load_strobe_n) fsh_q <= data[3:0];
			if (function_load_strobe_n && !fn_prev_q) func_q <= fsh_q;
		end
	end
	function automatic logic [15:0] line_exp(logic [3:0] f, logic s, logic [15:0] d,
		logic [3:0] a);
		logic [15:0] e;
		e = d;
		e[15 - a] = f[3 - {s, d[15 - a]}];
		return e;
	endfunction : line_exp
	////////////////////////////////////////////////////////////
	sequence s_low2(logic s);
		!s ##1 !s ##1 s;
	endsequence
	sequence s_line_steady;
		$past(line_mode) && $past(line_mode, 2) && !$past(rst_i) && $stable(dest_q)
			&& $stable(pixel_bit_select);
	endsequence
	property p_ctrl_pulse;
		$fell(control_load_strobe_n) |-> s_low2(control_load_strobe_n);
	endproperty
	property p_ctrl_data;
		!control_load_strobe_n && !$past(control_load_strobe_n) |-> $stable(data);
	endproperty
	property p_func_pulse;
		$fell(function_load_strobe_n) |-> s_low2(function_load_strobe_n);
	endproperty
	property p_func_data;
		!function_load_strobe_n && !$past(function_load_strobe_n) |-> $stable(data);
	endproperty
	property p_excl;
		!(!control_load_strobe_n && !function_load_strobe_n);
	endproperty
	property p_reset_quiet;
		$past(rst_i) |-> control_load_strobe_n && function_load_strobe_n
			&& !queue_read_strobe && !queue_write_strobe;
	endproperty
	property p_line;
		s_line_steady and $stable(pix_q) and $stable(func_q)
			|-> result == line_exp(func_q, pix_q, dest_q, pixel_bit_select);
	endproperty
	property p_line_one;
		s_line_steady |-> ((result ^ dest_q) & ~(16'h8000 >> pixel_bit_select)) == 16'h0000;
	endproperty
	property p_block_hold;
		!$past(line_mode) && !$past(queue_read_strobe) && !$past(rst_i) |-> $stable(result);
	endproperty
	a_ctrl_pulse: assert property (p_ctrl_pulse)
		else $error("control strobe low time wrong");
	a_ctrl_data: assert property (p_ctrl_data)
		else $error("data moved during control strobe");
	a_func_pulse: assert property (p_func_pulse)
		else $error("function strobe low time wrong");
	a_func_data: assert property (p_func_data)
		else $error("data moved during function strobe");
	a_excl: assert property (p_excl)
		else $error("both load strobes low");
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("link active after reset");
	a_line: assert property (p_line)
		else $error("line result wrong");
	a_line_one: assert property (p_line_one)
		else $error("line changed other bits");
	a_block_hold: assert property (p_block_hold)
		else $error("block result moved without read");
endmodule : bitblt_link_chk

// file: tb/bitblt_shift_mask_logic_unit_tb_top.sv
// Bench: controller user side drives the datapath across the link.
// Assumes one 100 MHz clock shared by both ends.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module bitblt_shift_mask_logic_unit_tb_top
	import bitblt_pkg::*;
();
	logic clk_i, rst_i, cyc, stb, we, ack;
	logic [3:0] adr;
	logic [1:0] sel;
	logic [15:0] wdat, rdat, s, w1, w2, lmk, rmk;
	int errors, check_count;
	bitblt_link_if link();
	raster_op_unit i_raster_op_unit(.clk_i(clk_i), .rst_i(rst_i), .link(link.device));
	raster_op_controller i_raster_op_controller(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .link(link.host));
	bitblt_link_chk i_bitblt_link_chk(.clk_i(clk_i), .rst_i(rst_i), .data(link.data),
		.control_load_strobe_n(link.control_load_strobe_n),
		.function_load_strobe_n(link.function_load_strobe_n),
		.dest_load(link.dest_load), .pixel_load(link.pixel_load),
		.queue_write_strobe(link.queue_write_strobe),
		.queue_read_strobe(link.queue_read_strobe), .line_mode(link.line_mode),
		.pixel_bit_select(link.pixel_bit_select), .result(link.result));
	////////////////////////////////////////////////////////////
	function automatic logic [15:0] rop(logic [3:0] f, logic [15:0] a, logic [15:0] d);
		return ({16{f[3]}} & ~a & ~d) | ({16{f[2]}} & ~a & d) | ({16{f[1]}} & a & ~d)
			| ({16{f[0]}} & a & d);
	endfunction : rop
	function automatic logic [15:0] bsh(logic [15:0] a, logic [15:0] b, int i);
		logic [31:0] t;
		t = {a, b} << i;
		return t[31:16];
	endfunction : bsh
	function automatic logic [15:0] cw(logic o, logic [3:0] sh, logic [3:0] lf, logic [3:0] rt);
		return {3'h0, o, sh, lf, rt};
	endfunction : cw
	// Classic single cycle; the request stands until ack is sampled high
	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d,
		output logic [15:0] v);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 2'b11;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		v = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : bus
	task automatic cmd(input op_t o, input logic [15:0] d);
		logic [15:0] v;
		bus(1'b1, o, d, v);
	endtask : cmd
	task automatic chk_read(input logic [15:0] exp);
		logic [15:0] v;
		cmd(OP_QREAD, 16'h0000);
		bus(1'b0, 4'h0, 16'h0000, v);
		`CHK(v, exp)
	endtask : chk_read
	task automatic end_sim();
		if (errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		#300000;
		errors++;
		end_sim();
	end
	initial begin
		errors = 0;
		check_count = 0;
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		sel = 2'b00;
		adr = 4'h0;
		wdat = 16'h0000;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		// Every function, shift and word order
		cmd(OP_MODE, 16'h0006);
		for (int f = 0; f < 16; f++) begin
			w1 = 16'hC35A + 16'(f);
			w2 = 16'h0F96 - 16'(f);
			cmd(OP_CTRL_RAW, cw(f[0], 4'(f), 4'h0, 4'hF));
			cmd(OP_FUNC, 16'(f));
			cmd(OP_SOURCE, w1);
			cmd(OP_SOURCE, w2);
			cmd(OP_QWRITE, 16'h0000);
			cmd(OP_DEST, 16'h5AA5 ^ 16'(f));
			s = f[0] ? bsh(w2, w1, f) : bsh(w1, w2, f);
			chk_read(rop(4'(f), s, 16'h5AA5 ^ 16'(f)));
		end
		// Edge masks under each enable combination
		cmd(OP_FUNC, 16'h000A);
		cmd(OP_DEST, 16'h3C3C);
		for (int n = 0; n < 16; n++) begin
			cmd(OP_CTRL_RAW, cw(1'b0, 4'h0, 4'(n), 4'(15 - n)));
			for (int m = 0; m < 4; m++) begin
				lmk = m[0] ? 16'hFFFF >> n : 16'hFFFF;
				rmk = m[1] ? ~(16'hFFFF >> (16 - n)) : 16'hFFFF;
				cmd(OP_MODE, 16'(m << 1));
				cmd(OP_QWRITE, 16'h0000);
				chk_read(16'h3C3C ^ (lmk & rmk));
			end
		end
		// Queue order and pointer wrap
		cmd(OP_CTRL_RAW, cw(1'b1, 4'h0, 4'h0, 4'hF));
		cmd(OP_FUNC, 16'h0003);
		cmd(OP_MODE, 16'h0000);
		for (int k = 0; k < 17; k++) begin
			cmd(OP_SOURCE, 16'h1000 + 16'(k * 273));
			cmd(OP_QWRITE, 16'h0000);
		end
		for (int k = 0; k < 17; k++) begin
			chk_read(16'h1000 + 16'(((k % 16 == 0) ? 16 : k) * 273));
		end
		// Line drawing on each pixel address
		cmd(OP_CTRL_RAW, cw(1'b0, 4'h0, 4'h0, 4'hF));
		cmd(OP_FUNC, 16'h0006);
		cmd(OP_PIXEL, 16'h0001);
		cmd(OP_DEST, 16'hA5C3);
		for (int p = 0; p < 16; p++) begin
			cmd(OP_MODE, 16'(p << 4) | 16'h0001);
			repeat (3) @(negedge clk_i);
			`CHK(link.result, 16'hA5C3 ^ (16'h8000 >> p))
		end
		// Control load refused in line mode
		cmd(OP_CTRL_RAW, cw(1'b0, 4'h0, 4'hF, 4'h0));
		cmd(OP_MODE, 16'h0006);
		cmd(OP_FUNC, 16'h000A);
		cmd(OP_QWRITE, 16'h0000);
		chk_read(16'h5A3C);
		// Address-derived control load: start 3, end 11, right-to-left, shift 4
		cmd(OP_CTRL_ADDR, 16'h09B3);
		cmd(OP_FUNC, 16'h0003);
		cmd(OP_SOURCE, 16'h1234);
		cmd(OP_SOURCE, 16'hABCD);
		cmd(OP_QWRITE, 16'h0000);
		chk_read(16'hBCD3);
		// Reset in mid-run realigns skewed queue pointers
		cmd(OP_QWRITE, 16'h0000);
		cmd(OP_QWRITE, 16'h0000);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		cmd(OP_FUNC, 16'h0003);
		cmd(OP_SOURCE, 16'h6E21);
		cmd(OP_SOURCE, 16'h0000);
		cmd(OP_QWRITE, 16'h0000);
		chk_read(16'h6E21);
		end_sim();
	end
endmodule : bitblt_shift_mask_logic_unit_tb_top
